// >>> inc/tsn_pkg.sv
// shared constants and types of the serial temperature sensor slave
// assumes a 50 MHz system clock and a separate link-side clock
package tsn_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_HZ    = 50_000_000;
	localparam int unsigned T_CONV_MS = 125;
	localparam int unsigned CONV_CYC  = T_CONV_MS * (CLK_HZ / 1000);

	// ************************************************************
	// slave address and command codes
	// ************************************************************
	localparam logic [3:0] ADDR_HI      = 4'h9;
	localparam logic [2:0] ADDR_SEL_DEF = 3'h5;
	localparam logic [7:0] CMD_TEMP     = 8'h00;
	localparam logic [7:0] CMD_CFG      = 8'h01;

	// ************************************************************
	// configuration byte layout and reset values
	// ************************************************************
	localparam int unsigned CFG_STBY_POS = 7;
	localparam int unsigned CFG_RDY_POS  = 6;
	localparam logic        STBY_RST     = 1'b0;
	localparam logic [7:0]  TEMP_RST     = 8'h00;
	localparam logic [3:0]  BIT_LAST     = 4'h8;

	// ************************************************************
	// link state machine
	// ************************************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_AACK = 4'b0010,
		ST_CMD  = 4'b0011,
		ST_CACK = 4'b0100,
		ST_WDAT = 4'b0101,
		ST_WACK = 4'b0110,
		ST_RDAT = 4'b0111,
		ST_RACK = 4'b1000
	} tsn_state_t;

endpackage

// >>> inc/tsn_conv_if.sv
// signals between the control top and the converter
// assumes the converter end runs on the system clock; the top takes ready, upd_tgl and temp on i_lclk
`timescale 1ns/1ps
interface tsn_conv_if;
	logic       standby;
	logic [7:0] sensor;
	logic [7:0] temp;
	logic       ready;
	logic       upd_tgl;

	modport conv (
		input  standby,
		input  sensor,
		output temp,
		output ready,
		output upd_tgl
	);
	modport ctl (
		output standby,
		output sensor,
		input  temp,
		input  ready,
		input  upd_tgl
	);
endinterface

// >>> logic/tsn_sync.sv
// two-flop synchroniser for levels
// assumes d is quasi-static relative to clk
`timescale 1ns/1ps
module tsn_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// data
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta_q <= '0;
			o_q    <= '0;
		end
		else
		begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule // tsn_sync

// >>> logic/tsn_conv.sv
// free-running conversion timer and temperature holding register
// assumes standby and sensor are already synchronous to i_clk
`timescale 1ns/1ps
module tsn_conv
	import tsn_pkg::*;
#(
	parameter int unsigned P_CONV_CYC = tsn_pkg::CONV_CYC
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// converter side
	tsn_conv_if.conv  cv
);
	import tsn_pkg::*;

	logic [31:0] cnt_q;
	logic        done;

	assign done = (cnt_q == 32'(P_CONV_CYC - 1));

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			cnt_q      <= '0;
			cv.temp    <= TEMP_RST;
			cv.ready   <= 1'b0;
			cv.upd_tgl <= 1'b0;
		end
		else if (cv.standby)
		begin
			// halted: result frozen, next run starts a full period
			cnt_q    <= '0;
			cv.ready <= 1'b0;
		end
		else if (done)
		begin
			cnt_q      <= '0;
			cv.temp    <= cv.sensor;
			cv.ready   <= 1'b1;
			cv.upd_tgl <= ~cv.upd_tgl;
		end
		else
			cnt_q <= cnt_q + 32'd1;
	end
endmodule // tsn_conv

// >>> logic/tsn_top.sv
// serial temperature sensor slave: two-wire slave port and registers
// assumes scl/sda pins are asynchronous and oversampled by i_lclk;
// the sensor front end delivers a two's-complement whole-degree byte.
//
// Notes on behaviour
// - first result and ready flag one 125 ms conversion period after reset
// - standby halts conversion and freezes the temperature value
// - the serial port works unchanged in standby
// - standby request bit: 0 converts normally, 1 selects standby
// - default slave address is 1001101 binary, others are ignored
// - address is a build-time choice of eight values
// - each result lands in the temperature register read by the port
// - temperature reads are served anytime with a completed result
// - slave only: never starts transfers, never drives the clock
// - bits move only on the master's serial clock edges
// - data line is open-drain, pulled low only for data or ack
// - command 00h selects temperature, 01h selects configuration
// - config: bit 7 standby, bit 6 ready, bits 5..0 read zero
// - ready flag clears at reset and standby, sets on fresh result
// - read is command write, repeated start, bytes until nack; bare read reuses
`timescale 1ns/1ps
module tsn_top
	import tsn_pkg::*;
#(
	parameter logic [2:0]  P_ADDR_SEL = tsn_pkg::ADDR_SEL_DEF,
	parameter int unsigned P_CONV_CYC = tsn_pkg::CONV_CYC
) (
	// system clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// link oversampling clock
	input  wire logic       i_lclk,
	// two-wire pins
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_o,
	output logic            o_sda_oe,
	// sensor front end
	input  wire logic [7:0] i_sensor,
	// status
	output logic      [7:0] o_temp,
	output logic            o_data_ready,
	output logic            o_standby
);
	import tsn_pkg::*;

	// ************************************************************
	// declarations
	// ************************************************************
	tsn_conv_if cvi ();

	logic       rst_l;
	logic [1:0] pin_n_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_p_q;
	logic       sda_p_q;
	logic       rdy_l;
	logic       tgl_l;
	logic       tgl_p_q;
	logic [7:0] temp_l_q;
	logic       stby_sys;

	tsn_state_t state_q;
	tsn_state_t state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [7:0] tx_q;
	logic [7:0] tx_d;
	logic       oe_q;
	logic       oe_d;
	logic       rw_q;
	logic       rw_d;
	logic       ptr_q;
	logic       ptr_d;
	logic       stby_q;
	logic       stby_d;
	logic       mack_q;
	logic       mack_d;

	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic       byte_done;
	logic [6:0] my_addr;
	logic       addr_hit;
	logic       cmd_ok;
	logic [7:0] cfg_rd;
	logic [7:0] tx_byte;
	logic       sh_new;

	// ************************************************************
	// link-side reset and pin synchronisers
	// ************************************************************
	tsn_sync #(.W(1)) u_rst_sync (
		.i_clk (i_lclk),
		.i_rst (1'b0),
		.i_d   (i_rst),
		.o_q   (rst_l)
	);

	tsn_sync #(.W(2)) u_pin_sync (
		.i_clk (i_lclk),
		.i_rst (rst_l),
		.i_d   (~{i_scl, i_sda}),
		.o_q   (pin_n_s)
	);

	// carried inverted so the cleared synchroniser reads as an idle bus,
	// otherwise the edge detector sees a false fall right after reset
	assign scl_s = ~pin_n_s[1];
	assign sda_s = ~pin_n_s[0];

	// ************************************************************
	// crossings between the link and the system clock
	// ************************************************************
	tsn_sync #(.W(1)) u_stby_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   (stby_q),
		.o_q   (stby_sys)
	);

	tsn_sync #(.W(2)) u_stat_sync (
		.i_clk (i_lclk),
		.i_rst (rst_l),
		.i_d   ({cvi.ready, cvi.upd_tgl}),
		.o_q   ({rdy_l, tgl_l})
	);

	tsn_sync #(.W(8)) u_sens_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   (i_sensor),
		.o_q   (cvi.sensor)
	);

	assign cvi.standby = stby_sys;

	// ************************************************************
	// converter
	// ************************************************************
	tsn_conv #(.P_CONV_CYC(P_CONV_CYC)) u_conv (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.cv    (cvi.conv)
	);

	// ************************************************************
	// status outputs, system domain
	// ************************************************************
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_temp       <= TEMP_RST;
			o_data_ready <= 1'b0;
			o_standby    <= STBY_RST;
		end
		else
		begin
			o_temp       <= cvi.temp;
			o_data_ready <= cvi.ready;
			o_standby    <= stby_sys;
		end
	end

	// ************************************************************
	// bus decode
	// ************************************************************
	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign byte_done = scl_fall & (cnt_q == BIT_LAST);
	assign my_addr   = {ADDR_HI, P_ADDR_SEL};
	assign addr_hit  = (sh_q[7:1] == my_addr);
	assign cmd_ok    = (sh_q == CMD_TEMP) | (sh_q == CMD_CFG);
	assign sh_new    = (tgl_l != tgl_p_q);

	// reserved bits always read back as zero
	assign cfg_rd = {stby_q, rdy_l, 6'h00};
	// temperature comes from the shadow copy, never a half-done value
	assign tx_byte = ptr_q ? cfg_rd : temp_l_q;

	// ************************************************************
	// temperature shadow in the link domain
	// ************************************************************
	// the system side holds temp stable for a whole conversion period
	// after toggling, so the word is safe to take on the seen toggle
	always_ff @(posedge i_lclk)
	begin
		if (rst_l)
		begin
			tgl_p_q  <= 1'b0;
			temp_l_q <= TEMP_RST;
		end
		else
		begin
			tgl_p_q <= tgl_l;
			if (sh_new)
				temp_l_q <= cvi.temp;
		end
	end

	// ************************************************************
	// slave state machine, next state
	// ************************************************************
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		tx_d    = tx_q;
		oe_d    = oe_q;
		rw_d    = rw_q;
		ptr_d   = ptr_q;
		stby_d  = stby_q;
		mack_d  = mack_q;
		if (start_det)
		begin
			// also covers the repeated start of a register read
			state_d = ST_ADDR;
			cnt_d   = 4'h0;
			oe_d    = 1'b0;
		end
		else if (stop_det)
		begin
			state_d = ST_IDLE;
			oe_d    = 1'b0;
		end
		else
		begin
			unique case (state_q)
			ST_IDLE:
				oe_d = 1'b0;
			ST_ADDR, ST_CMD, ST_WDAT:
			begin
				if (scl_rise)
				begin
					sh_d  = {sh_q[6:0], sda_s};
					cnt_d = cnt_q + 4'h1;
				end
				else if (byte_done)
				begin
					cnt_d = 4'h0;
					unique case (state_q)
					ST_ADDR:
					begin
						rw_d    = sh_q[0];
						state_d = addr_hit ? ST_AACK : ST_IDLE;
						oe_d    = addr_hit;
					end
					ST_CMD:
					begin
						ptr_d   = cmd_ok ? sh_q[0] : ptr_q;
						state_d = cmd_ok ? ST_CACK : ST_IDLE;
						oe_d    = cmd_ok;
					end
					default:
					begin
						// standby does not gate the port at all
						if (ptr_q)
							stby_d = sh_q[CFG_STBY_POS];
						state_d = ST_WACK;
						oe_d    = 1'b1;
					end
					endcase
				end
			end
			ST_AACK:
			begin
				if (scl_fall)
				begin
					if (rw_q)
					begin
						// bare receive reuses the last pointer
						tx_d    = tx_byte;
						oe_d    = ~tx_byte[7];
						state_d = ST_RDAT;
					end
					else
					begin
						oe_d    = 1'b0;
						state_d = ST_CMD;
					end
				end
			end
			ST_CACK, ST_WACK:
			begin
				if (scl_fall)
				begin
					oe_d    = 1'b0;
					state_d = ST_WDAT;
				end
			end
			ST_RDAT:
			begin
				if (scl_rise)
					cnt_d = cnt_q + 4'h1;
				else if (byte_done)
				begin
					oe_d    = 1'b0;
					state_d = ST_RACK;
				end
				else if (scl_fall)
				begin
					tx_d = {tx_q[6:0], 1'b0};
					oe_d = ~tx_q[6];
				end
			end
			ST_RACK:
			begin
				if (scl_rise)
					mack_d = ~sda_s;
				else if (scl_fall)
				begin
					cnt_d = 4'h0;
					if (mack_q)
					begin
						tx_d    = tx_byte;
						oe_d    = ~tx_byte[7];
						state_d = ST_RDAT;
					end
					else
					begin
						// nack ends the read; wait for stop
						oe_d    = 1'b0;
						state_d = ST_IDLE;
					end
				end
			end
			default:
			begin
				state_d = ST_IDLE;
				oe_d    = 1'b0;
			end
			endcase
		end
	end

	// ************************************************************
	// slave state machine, registers
	// ************************************************************
	always_ff @(posedge i_lclk)
	begin
		if (rst_l)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			tx_q    <= 8'h00;
			oe_q    <= 1'b0;
			rw_q    <= 1'b0;
			ptr_q   <= 1'b0;
			stby_q  <= STBY_RST;
			mack_q  <= 1'b0;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			tx_q    <= tx_d;
			oe_q    <= oe_d;
			rw_q    <= rw_d;
			ptr_q   <= ptr_d;
			stby_q  <= stby_d;
			mack_q  <= mack_d;
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// ************************************************************
	// pin drivers
	// ************************************************************
	// open drain: only ever pulls low, the pull-up makes the high
	always_ff @(posedge i_lclk)
	begin
		if (rst_l)
		begin
			o_sda_o  <= 1'b0;
			o_sda_oe <= 1'b0;
		end
		else
		begin
			o_sda_o  <= 1'b0;
			o_sda_oe <= oe_q;
		end
	end

endmodule // tsn_top

// >>> verification/tsn_props.sv
// assertions on the sensor slave top-level ports
// assumes it is bound into tsn_top and sees its ports only
`timescale 1ns/1ps
module tsn_props #(
	parameter int unsigned P_CONV_CYC = 200
) (
	// clocks and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_lclk,
	// two-wire pins
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       o_sda_o,
	input  wire logic       o_sda_oe,
	// sensor and status
	input  wire logic [7:0] i_sensor,
	input  wire logic [7:0] o_temp,
	input  wire logic       o_data_ready,
	input  wire logic       o_standby
);
	// ********
	// helpers
	// ********
	logic        scl_q;
	logic        sda_q;
	logic        busy_q;
	int unsigned wait_q;
	wire         frz  = o_standby && !o_data_ready;
	wire         st_w = scl_q && i_scl && sda_q && !i_sda;
	wire         sp_w = scl_q && i_scl && !sda_q && i_sda;
	// raw pin view; the design's synchroniser only lags behind it
	always_ff @(posedge i_lclk)
	begin
		scl_q  <= i_scl;
		sda_q  <= i_sda;
		busy_q <= !i_rst && (st_w || (busy_q && !sp_w));
	end
	always_ff @(posedge i_clk)
		wait_q <= (i_rst || o_data_ready || o_standby) ? 0 : wait_q + 1;
	sequence s_stby_in;
		$rose(o_standby);
	endsequence
	sequence s_frozen;
		frz ##1 frz;
	endsequence
	a_pin_low: assert property (
		@(posedge i_lclk) disable iff (i_rst) !o_sda_o)
		else $error("sda drive value not low");
	a_oe_scl_low: assert property (
		@(posedge i_lclk) disable iff (i_rst) $changed(o_sda_oe) |-> !i_scl)
		else $error("sda enable moved while scl high");
	a_oe_in_frame: assert property (
		@(posedge i_lclk) disable iff (i_rst) o_sda_oe |-> busy_q)
		else $error("sda driven outside a frame");
	a_temp_frozen: assert property (
		@(posedge i_clk) disable iff (i_rst) s_frozen |-> $stable(o_temp))
		else $error("temperature moved in standby");
	a_rdy_stby_clr: assert property (
		@(posedge i_clk) disable iff (i_rst) s_stby_in |-> ##[0:2] !o_data_ready)
		else $error("ready not cleared on standby");
	a_rdy_stays_low: assert property (
		@(posedge i_clk) disable iff (i_rst) frz |=> !o_data_ready || !o_standby)
		else $error("ready set during standby");
	a_rdy_time: assert property (
		@(posedge i_clk) disable iff (i_rst) wait_q <= P_CONV_CYC + 8)
		else $error("conversion result late");
	a_temp_src: assert property (
		@(posedge i_clk) disable iff (i_rst) $rose(o_data_ready) |-> o_temp == i_sensor)
		else $error("result not taken from sensor");
	a_temp_with_rdy: assert property (
		@(posedge i_clk) disable iff (i_rst) $changed(o_temp) |-> ##[0:2] o_data_ready)
		else $error("temperature moved without a result");
endmodule // tsn_props
bind tsn_top tsn_props #(.P_CONV_CYC(P_CONV_CYC)) u_props (
	.i_clk(i_clk), .i_rst(i_rst), .i_lclk(i_lclk), .i_scl(i_scl),
	.i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
	.i_sensor(i_sensor), .o_temp(o_temp), .o_data_ready(o_data_ready),
	.o_standby(o_standby)
);

// >>> verification/tsn_host.sv
// two-wire bus master model driving the serial clock and data line
// assumes a pull-up on the data line and i_lclk as its time base
`timescale 1ns/1ps
module tsn_host #(
	parameter int Q = 32
) (
	// time base
	input  wire logic i_lclk,
	// wire
	input  wire logic i_dev_oe,
	output logic      o_scl,
	output logic      o_sda
);
	logic m_low = 1'h0;
	// open drain: any party low wins, otherwise the pull-up
	assign o_sda = !(m_low || i_dev_oe);
	initial o_scl = 1'h1;
	task automatic st(input logic c, input logic l);
		o_scl = c;
		m_low = l;
		repeat (Q) @(posedge i_lclk);
		#1;
	endtask
	// start and repeated start; scl stands still between frames
	task automatic start();
		st(o_scl, 1'h0);
		st(1'h1, 1'h0);
		st(1'h1, 1'h1);
		st(1'h0, 1'h1);
	endtask
	task automatic stop();
		st(1'h0, 1'h1);
		st(1'h1, 1'h1);
		st(1'h1, 1'h0);
	endtask
	// data only moves while scl is low
	task automatic bit_io(input logic b, output logic r);
		st(1'h0, !b);
		st(1'h1, !b);
		r = o_sda;
		st(1'h1, !b);
		st(1'h0, !b);
	endtask
	// eight bits msb first, then the ninth bit
	task automatic xfer(input logic [7:0] t, input logic b9,
		output logic [7:0] r, output logic a9);
		for (int i = 7; i >= 0; i--)
			bit_io(t[i], r[i]);
		bit_io(b9, a9);
	endtask
endmodule // tsn_host

// >>> verification/testbench.sv
// self-checking bench for the serial temperature sensor slave
// assumes the host model on the wire and a short conversion period
`timescale 1ns/1ps
module testbench;
	import tsn_pkg::*;
	localparam int unsigned P   = 200;
	localparam int          LIM = 80_000;
	localparam logic [6:0]  ADR = {ADDR_HI, ADDR_SEL_DEF};
	logic       i_clk = 1'h0;
	logic       i_lclk = 1'h0;
	logic       i_rst;
	logic [7:0] i_sensor;
	logic       scl;
	logic       sda;
	logic       sda_o;
	logic       sda_oe;
	logic [7:0] temp;
	logic       rdy;
	logic       stby;
	int         fail_count = 0;
	int         n_checks = 0;
	int         cyc = 0;
	always #10 i_clk = ~i_clk;
	initial
	begin
		#7;
		forever #15 i_lclk = ~i_lclk;
	end
	tsn_top #(.P_CONV_CYC(P)) DUT (
		.i_clk(i_clk), .i_rst(i_rst), .i_lclk(i_lclk), .i_scl(scl),
		.i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
		.i_sensor(i_sensor), .o_temp(temp), .o_data_ready(rdy),
		.o_standby(stby)
	);
	tsn_host host (
		.i_lclk(i_lclk), .i_dev_oe(sda_oe), .o_scl(scl), .o_sda(sda)
	);
	// ********
	// tasks
	// ********
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			$display("Error at %0t got %h expected %h", $time, g, e);
			fail_count++;
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wait_rdy();
		int i = 0;
		while (rdy !== 1'h1 && i < P + 20)
		begin
			tick(1);
			i++;
		end
		chk1(rdy, 1'h1);
	endtask
	// one byte out; the ninth bit is released and sampled
	task automatic snd(input logic [7:0] b, input logic e);
		logic [7:0] r;
		logic       k;
		host.xfer(b, 1'h1, r, k);
		chk1(k, e);
	endtask
	task automatic rcv(input logic [7:0] e);
		logic [7:0] r;
		logic       k;
		host.start();
		snd({ADR, 1'h1}, 1'h0);
		host.xfer(8'hFF, 1'h1, r, k);
		chk8(r, e);
		host.stop();
	endtask
	task automatic rd(input logic [7:0] c, input logic [7:0] e);
		host.start();
		snd({ADR, 1'h0}, 1'h0);
		snd(c, 1'h0);
		rcv(e);
	endtask
	// a refused address sends nothing after the address byte
	task automatic wr(input logic [6:0] a, input logic [7:0] d,
		input logic e);
		host.start();
		snd({a, 1'h0}, e);
		if (!e)
		begin
			snd(CMD_CFG, 1'h0);
			snd(d, 1'h0);
		end
		host.stop();
	endtask
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == LIM)
		begin
			fail_count++;
			summarize();
		end
	end
	// ********
	// sequence
	// ********
	initial
	begin
		i_rst = 1'h1;
		i_sensor = 8'hE7;
		tick(20);
		i_rst = 1'h0;
		chk8(temp, TEMP_RST);
		chk1(rdy, 1'h0);
		chk1(stby, STBY_RST);
		wait_rdy();
		chk8(temp, 8'hE7);
		rd(CMD_TEMP, 8'hE7);
		rd(CMD_CFG, 8'h40);
		wr({ADDR_HI, 3'h4}, 8'h80, 1'h1);
		chk1(stby, 1'h0);
		wr(ADR, 8'h80, 1'h0);
		tick(5);
		chk1(stby, 1'h1);
		chk1(rdy, 1'h0);
		i_sensor = 8'h19;
		tick(3 * P);
		chk8(temp, 8'hE7);
		rd(CMD_CFG, 8'h80);
		// unknown command is refused and must not move the pointer
		host.start();
		snd({ADR, 1'h0}, 1'h0);
		snd(8'h02, 1'h1);
		host.stop();
		rcv(8'h80);
		wr(ADR, 8'h00, 1'h0);
		wait_rdy();
		chk8(temp, 8'h19);
		rcv(8'h40);
		summarize();
	end
endmodule // testbench
